// ===== ldeq_host.sv
/*
  management host model: issues single-byte register writes.
  assumes the bench raises wr_i for one cycle per write, just after an edge.
*/
`timescale 1ns/100ps
module ldeq_host (
  input wire logic clk_i,
  input wire logic wr_i,
  input wire logic [7:0] a_i,
  input wire logic [7:0] d_i,
  output logic wr_en_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  // address follows a_i every cycle, so readback stays on the register left on a_i;
  // data is scrambled between writes so a stale byte cannot pass unseen
  always_ff @(posedge clk_i) begin
    wr_en_o <= wr_i;
    addr_o <= a_i;
    wdata_o <= wr_i ? d_i : ~wdata_o;
  end
endmodule // ldeq_host

// ===== ldeq_pkg.sv
/*
  constants for the lane disable and equalizer select register bank.
  assumes an 8-bit register port driven by a management interface block.
*/
package ldeq_pkg;
  // ****************************************************
  // register offsets
  // ****************************************************
  localparam logic [7:0] LDEQ_ADDR_LANE_CTRL = 8'h13;
  localparam logic [7:0] LDEQ_ADDR_DS_EQ = 8'h20;
  localparam logic [7:0] LDEQ_ADDR_US_EQ = 8'h21;
  // ****************************************************
  // field positions and reset values
  // ****************************************************
  localparam int LDEQ_MON_OFF_BIT = 7;
  localparam int LDEQ_ROUTE_LSB = 4;
  localparam int LDEQ_SECOND_LSB = 4;
  localparam logic [7:0] LDEQ_LANE_CTRL_MASK = 8'hBF;
  localparam logic [7:0] LDEQ_US_EQ_MASK = 8'h0F;
  localparam logic [7:0] LDEQ_RESET_VAL = 8'h00;
  localparam logic [1:0] LDEQ_ROUTE_AUTO = 2'h0;
  localparam logic [1:0] LDEQ_ROUTE_STRAIGHT = 2'h1;
  localparam logic [1:0] LDEQ_ROUTE_CROSSED = 2'h2;
  localparam logic [1:0] LDEQ_ROUTE_OPEN = 2'h3;
endpackage

// ===== ldeq_regs.sv
/*
  lane disable, sideband routing and receiver equalizer select registers.
  assumes a synchronous byte register port on clk_i from an i2c target,
  strap levels and lane count arriving asynchronously from pins/monitor.
*/
`timescale 1ns/100ps
module ldeq_regs
  import ldeq_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic wr_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic equalizer_software_control_i,
  input wire logic configuration_select_high_bit_i,
  input wire logic orientation_select_i,
  input wire logic [1:0] usb_eq_strap_pins_i,
  input wire logic [1:0] upstream_eq_strap_pins_i,
  input wire logic [4:0] monitored_lane_count_i,
  output logic [7:0] rdata_o,
  output logic [3:0] lane_enable_o,
  output logic auxp_sbu1_o,
  output logic auxn_sbu2_o,
  output logic auxp_sbu2_o,
  output logic auxn_sbu1_o,
  output logic [3:0] first_rx_equalizer_level_o,
  output logic [3:0] second_rx_equalizer_level_o,
  output logic [3:0] upstream_equalizer_level_o
);
  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    logic [1:0] ds_s1;
    logic [1:0] ds_s2;
    logic [1:0] us_s1;
    logic [1:0] us_s2;
    logic [4:0] lc_s1;
    logic [4:0] lc_s2;
    logic [7:0] lane_ctrl;
    logic [7:0] ds_eq;
    logic [7:0] us_eq;
    logic [7:0] rdata;
    logic [3:0] lane_en;
    logic [3:0] route;
    logic [3:0] eq1;
    logic [3:0] eq2;
    logic [3:0] equs;
  } ldeq_state_t;

  ldeq_state_t state_r;
  ldeq_state_t state_nxt;

  // strap code widened into the four-bit level field
  function automatic logic [3:0] ldeq_strap_level(input logic [1:0] s);
    return {2'h0, s};
  endfunction

  // lanes implied by the monitored lane count (none, 1, 2 or 4)
  function automatic logic [3:0] ldeq_count_lanes(input logic [4:0] c);
    logic [3:0] m;
    m = 4'h0;
    if (c >= 5'h04) begin
      m = 4'hF;
    end else if (c >= 5'h02) begin
      m = 4'h3;
    end else if (c == 5'h01) begin
      m = 4'h1;
    end
    return m;
  endfunction

  logic mon_off;
  logic [1:0] route_ovr;
  logic [3:0] auto_route;

  always_comb begin
    state_nxt = state_r;
    // pins and monitor are asynchronous: two flops before use
    state_nxt.ds_s1 = usb_eq_strap_pins_i;
    state_nxt.ds_s2 = state_r.ds_s1;
    state_nxt.us_s1 = upstream_eq_strap_pins_i;
    state_nxt.us_s2 = state_r.us_s1;
    state_nxt.lc_s1 = monitored_lane_count_i;
    state_nxt.lc_s2 = state_r.lc_s1;
    // ****************************************************
    // register writes
    // ****************************************************
    if (wr_en_i) begin
      unique case (addr_i)
        LDEQ_ADDR_LANE_CTRL: begin
          state_nxt.lane_ctrl = wdata_i & LDEQ_LANE_CTRL_MASK;
        end
        LDEQ_ADDR_DS_EQ: begin
          if (equalizer_software_control_i) begin
            state_nxt.ds_eq = wdata_i;
          end
        end
        LDEQ_ADDR_US_EQ: begin
          if (equalizer_software_control_i) begin
            state_nxt.us_eq = wdata_i & LDEQ_US_EQ_MASK;
          end
        end
        default: begin
        end
      endcase
    end
    // strap mirror wins whenever software control is low
    if (!equalizer_software_control_i) begin
      state_nxt.ds_eq = {ldeq_strap_level(state_r.ds_s2),
                         ldeq_strap_level(state_r.ds_s2)};
      state_nxt.us_eq = {4'h0, ldeq_strap_level(state_r.us_s2)};
    end
    // ****************************************************
    // readback
    // ****************************************************
    unique case (addr_i)
      LDEQ_ADDR_LANE_CTRL: state_nxt.rdata = state_r.lane_ctrl;
      LDEQ_ADDR_DS_EQ: state_nxt.rdata = state_r.ds_eq;
      LDEQ_ADDR_US_EQ: state_nxt.rdata = state_r.us_eq;
      default: state_nxt.rdata = 8'h00;
    endcase
    // ****************************************************
    // lane enables and sideband routing
    // ****************************************************
    mon_off = state_r.lane_ctrl[LDEQ_MON_OFF_BIT];
    if (mon_off) begin
      state_nxt.lane_en = ~state_r.lane_ctrl[3:0];
    end else begin
      // lane off bits ignored here
      state_nxt.lane_en = ldeq_count_lanes(state_r.lc_s2);
    end
    // route bits: {auxp_sbu1, auxn_sbu2, auxp_sbu2, auxn_sbu1}
    auto_route = 4'h0;
    if (configuration_select_high_bit_i) begin
      auto_route = orientation_select_i ? 4'h3 : 4'hC;
    end
    route_ovr = state_r.lane_ctrl[LDEQ_ROUTE_LSB +: 2];
    unique case (route_ovr)
      LDEQ_ROUTE_AUTO: state_nxt.route = auto_route;
      LDEQ_ROUTE_STRAIGHT: state_nxt.route = 4'hC;
      LDEQ_ROUTE_CROSSED: state_nxt.route = 4'h3;
      LDEQ_ROUTE_OPEN: state_nxt.route = 4'h0;
    endcase
    // equalizer levels follow the effective field values
    state_nxt.eq1 = state_r.ds_eq[3:0];
    state_nxt.eq2 = state_r.ds_eq[LDEQ_SECOND_LSB +: 4];
    state_nxt.equs = state_r.us_eq[3:0];
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rdata_o = state_r.rdata;
  assign lane_enable_o = state_r.lane_en;
  assign auxp_sbu1_o = state_r.route[3];
  assign auxn_sbu2_o = state_r.route[2];
  assign auxp_sbu2_o = state_r.route[1];
  assign auxn_sbu1_o = state_r.route[0];
  assign first_rx_equalizer_level_o = state_r.eq1;
  assign second_rx_equalizer_level_o = state_r.eq2;
  assign upstream_equalizer_level_o = state_r.equs;

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // compare against the previous cycle: a write may land on the same edge
  a_lane_manual: assert property (
    mon_off |=> lane_enable_o == ~$past(state_r.lane_ctrl[3:0]))
    else $error("lane enables do not follow lane off bits");
  a_lane_ignore: assert property (
    !mon_off |=> lane_enable_o == ldeq_count_lanes($past(state_r.lc_s2)))
    else $error("lane enables not from monitored count");
  a_route_open: assert property (
    route_ovr == LDEQ_ROUTE_OPEN |=> state_r.route == 4'h0)
    else $error("override open did not open paths");
  a_route_straight: assert property (
    route_ovr == LDEQ_ROUTE_STRAIGHT |=> auxp_sbu1_o && auxn_sbu2_o
      && !auxp_sbu2_o && !auxn_sbu1_o)
    else $error("straight override wrong");
  a_route_crossed: assert property (
    route_ovr == LDEQ_ROUTE_CROSSED |=> auxp_sbu2_o && auxn_sbu1_o
      && !auxp_sbu1_o && !auxn_sbu2_o)
    else $error("crossed override wrong");
  a_route_auto: assert property (
    route_ovr == LDEQ_ROUTE_AUTO && !configuration_select_high_bit_i
      |=> state_r.route == 4'h0)
    else $error("auto route connected without config bit");
  a_route_follow: assert property (
    route_ovr == LDEQ_ROUTE_AUTO && configuration_select_high_bit_i
      |=> auxp_sbu1_o == !$past(orientation_select_i)
      && auxp_sbu2_o == $past(orientation_select_i))
    else $error("auto route does not follow orientation");
  a_eq_mirror: assert property (
    !equalizer_software_control_i ##1 !equalizer_software_control_i
      |-> state_r.ds_eq[3:0] == {2'h0, $past(state_r.ds_s2)})
    else $error("downstream eq not mirroring straps");
  a_eq_us_sw: assert property (
    equalizer_software_control_i && wr_en_i && addr_i == LDEQ_ADDR_US_EQ
      |=> ##1 upstream_equalizer_level_o == $past(wdata_i[3:0], 2))
    else $error("upstream eq write not applied");
  a_reserved_zero: assert property (
    state_r.lane_ctrl[6] == 1'b0 && state_r.us_eq[7:4] == 4'h0)
    else $error("reserved bit set");

  c_mon_off: cover property (mon_off && lane_enable_o != 4'hF);
  c_sw_eq: cover property (equalizer_software_control_i && wr_en_i
    && addr_i == LDEQ_ADDR_DS_EQ);
  c_crossed: cover property (route_ovr == LDEQ_ROUTE_CROSSED);
  c_four_lanes: cover property (!mon_off && lane_enable_o == 4'hF);
endmodule // ldeq_regs

// ===== ldeq_regs_tb.sv
/*
  self-checking bench for the register bank: row table, then hand tests.
  assumes level outputs settle within five cycles of a host write.
*/
`timescale 1ns/100ps
module ldeq_regs_tb;
  import ldeq_pkg::*;
  logic clk_i = 1'b0, reset_n_i = 1'b0, wr = 1'b0;
  logic sw = 1'b0, cfg = 1'b0, ori = 1'b0, wr_en, p1, n2, p2, n1;
  logic [1:0] eqs = 2'h0, ueqs = 2'h0;
  logic [4:0] cnt = 5'h00;
  logic [7:0] a = 8'h00, d = 8'h00, addr, wdata, rdata;
  logic [3:0] lane, e1, e2, eu;
  logic [55:0] rows [11];
  int errors = 0, comparisons = 0;

  always #20 clk_i = ~clk_i;

  ldeq_host ldeq_host_i (.clk_i(clk_i), .wr_i(wr), .a_i(a), .d_i(d),
    .wr_en_o(wr_en), .addr_o(addr), .wdata_o(wdata));

  ldeq_regs ldeq_regs_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .wr_en_i(wr_en), .addr_i(addr), .wdata_i(wdata),
    .equalizer_software_control_i(sw),
    .configuration_select_high_bit_i(cfg), .orientation_select_i(ori),
    .usb_eq_strap_pins_i(eqs), .upstream_eq_strap_pins_i(ueqs),
    .monitored_lane_count_i(cnt), .rdata_o(rdata), .lane_enable_o(lane),
    .auxp_sbu1_o(p1), .auxn_sbu2_o(n2), .auxp_sbu2_o(p2),
    .auxn_sbu1_o(n1), .first_rx_equalizer_level_o(e1),
    .second_rx_equalizer_level_o(e2), .upstream_equalizer_level_o(eu));

  // ****************************************************
  // shared tasks
  // ****************************************************
  task automatic chk(input string nm, input logic [27:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // entered just after an edge; returns just after an edge
  task automatic put;
    wr = 1'b1;
    @(posedge clk_i) #1 wr = 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
  endtask

  task automatic end_sim;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #40000;
    errors = errors + 1;
    end_sim;
  end

  // ****************************************************
  // main sequence
  // ****************************************************
  // row: {sw,cfg,ori}, {straps}, count, addr, data,
  // then {rdata, lanes, p1 n2 p2 n1, eq1, eq2, eq up}
  initial begin
    rows[0] = {3'h2, 4'hB, 5'h02, 16'h1340, 28'h003C223};
    rows[1] = {3'h3, 4'hB, 5'h05, 16'h20FF, 28'h22F3223};
    rows[2] = {3'h0, 4'hB, 5'h01, 16'h1310, 28'h101C223};
    rows[3] = {3'h0, 4'hB, 5'h00, 16'h1320, 28'h2003223};
    rows[4] = {3'h2, 4'hB, 5'h04, 16'h133F, 28'h3FF0223};
    rows[5] = {3'h2, 4'hB, 5'h04, 16'h1385, 28'h85AC223};
    rows[6] = {3'h6, 4'hB, 5'h04, 16'h2093, 28'h93AC393};
    rows[7] = {3'h6, 4'h7, 5'h04, 16'h21FB, 28'h0BAC39B};
    rows[8] = {3'h6, 4'h7, 5'h04, 16'h3099, 28'h00AC39B};
    rows[9] = {3'h2, 4'h7, 5'h04, 16'h2100, 28'h03AC113};
    rows[10] = {3'h1, 4'h7, 5'h04, 16'h1380, 28'h80F0113};
    repeat (10) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    for (int i = 0; i < 11; i++) begin
      {sw, cfg, ori, eqs, ueqs, cnt, a, d} = rows[i][55:28];
      put;
      chk("row", {rdata, lane, p1, n2, p2, n1, e1, e2, eu},
        rows[i][27:0]);
      $display("row %0d done", i);
    end
    // back-to-back writes with the strobe held across two edges
    sw = 1'b1;
    a = 8'h13;
    d = 8'h87;
    wr = 1'b1;
    @(posedge clk_i) #1 a = 8'h20;
    d = 8'h5A;
    put;
    chk("back_to_back", {rdata, lane, e1, e2, 8'h00}, 28'h5A8A500);
    $display("back to back done");
    // reset in mid-run clears every output
    reset_n_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk("reset", {rdata, lane, p1, n2, p2, n1, e1, e2, eu}, 28'h0);
    $display("reset done");
    end_sim;
  end
endmodule // ldeq_regs_tb
